// [core/dfs_pkg.sv]
/*
 * Package for the drive fault and status-code block: status codes,
 * cylinder limit, timing figures, controller states and line bundle.
 * Assumes a single 10 MHz clock shared by all users of the package.
 */
package dfs_pkg;

    // Status codes shown on the diagnostic display
    localparam logic [7:0] CODE_NONE = 8'h00;     // No fault held
    localparam logic [7:0] CODE_SEEK_TMO = 8'h46; // Seek took too long
    localparam logic [7:0] CODE_SERVO = 8'h4a;    // Servo error, any motion
    localparam logic [7:0] CODE_LOST_CYL = 8'h4b; // On-cylinder sense lost
    localparam logic [7:0] CODE_BAD_CYL = 8'h4d;  // Address above the top
    localparam logic [7:0] CODE_VOLT = 8'h4e;     // Voltage fault on cylinder
    localparam logic [7:0] CODE_FAN = 8'h5c;      // Cooling fan fault
    localparam logic [7:0] CODE_PIA = 8'h5f;      // Adapter self-test failed
    localparam logic [7:0] CODE_MPU = 8'hff;      // Processor self-test failed

    // Geometry
    localparam logic [9:0] CYL_MAX = 10'h336;     // Highest cylinder, 822
    localparam logic [9:0] CYL_HOME = 10'h000;    // Cylinder zero

    // Timing
    localparam int CLK_HZ = 10_000_000;           // Clock rate
    localparam int SEEK_TMO_MS = 65;              // Seek timeout, ms
    localparam int FAN_TMO_MS = 400;              // Fan fault hold, ms
    localparam int SEEK_TMO_CYC = SEEK_TMO_MS * (CLK_HZ / 1000);
    localparam int FAN_TMO_CYC = FAN_TMO_MS * (CLK_HZ / 1000);
    localparam int TMR_W = 23;                    // Timer width

    // Controller states
    typedef enum logic [3:0] {
        ST_POST,      // Power-on self test
        ST_HALT,      // Self test failed, wait for power cycle
        ST_LOAD,      // Head load, ends on cylinder zero
        ST_LOAD_FLT,  // Servo error during first seek
        ST_READY,     // On cylinder, idle
        ST_SEEK,      // Normal seek
        ST_RTZ,       // Return to track zero
        ST_SEEK_ERR,  // Seek error, servo off
        ST_VFAULT,    // Voltage fault, actuator free
        ST_FAN_STOP   // Drive stopped by fan fault
    } dfs_state_type;

    // Interface lines driven towards the controller and the drive
    typedef struct packed {
        logic seek_error;
        logic seek_end;
        logic on_cyl;
        logic ready;
        logic fault;
        logic servo_en;
        logic motor_run;
        logic leds_all;
    } dfs_lines_type;

    localparam dfs_lines_type LINES_RST = '0;     // All lines quiet

endpackage

// [core/dfs_drive_fault.sv]
/*
 * Fault detection and status-code controller of a fixed disk drive.
 * Assumes all inputs synchronous to MCLK_IN, single-cycle command
 * pulses from the controller, and that on-cylinder sense drops within
 * one cycle of a seek start. Reset models the main breaker cycle.
 */
// Function
// R1 - Lost sense: code 4B, seek error, servo off
// R2 - Return to track zero clears error, seeks zero
// R3 - Servo error in return: retry on next command
// R4 - First-seek servo error: fault clear reloads heads
// R5 - Cylinder above 822: code 4D, seek error/end
// R6 - Voltage fault on cylinder: code 4E, fault
// R7 - Voltage gone, clear then return: reload, zero
// R8 - Fan fault code 5C; stop after 400 ms
// R9 - Keep clearing fan; restart when all clear
// R10 - Adapter test fails: code 5F, halt, lamps
// R11 - Processor test fails: code FF, halt, lamps
// R12 - Only breaker power cycle clears self-test halt
// R13 - Seek over 65 ms: code 46, servo off
// R14 - Hold latest code until recovery clears it
`timescale 1ns/1ps
module dfs_drive_fault
    import dfs_pkg::*;
#(
    parameter int SEEK_CYC = SEEK_TMO_CYC,   // Seek timeout in cycles
    parameter int FAN_CYC = FAN_TMO_CYC      // Fan stop delay in cycles
) (
    // Clock, reset, enable
    input wire logic MCLK_IN,
    input wire logic RST_N_IN,
    input wire logic CE_IN,
    // Self test results
    input wire logic POST_DONE_IN,
    input wire logic PIA_FAIL_IN,
    input wire logic MPU_FAIL_IN,
    // Controller commands
    input wire logic SEEK_REQ_IN,
    input wire logic [9:0] CYL_ADDR_IN,
    input wire logic RTZ_IN,
    input wire logic FAULT_CLEAR_IN,
    // Drive sensing
    input wire logic ON_CYL_SENSE_IN,
    input wire logic SERVO_ERR_IN,
    input wire logic VOLT_FAULT_IN,
    input wire logic FAN_FAULT_IN,
    // Interface lines
    output logic SEEK_ERROR_OUT,
    output logic SEEK_END_OUT,
    output logic ON_CYL_OUT,
    output logic READY_OUT,
    output logic FAULT_OUT,
    // Drive control
    output logic SERVO_EN_OUT,
    output logic MOTOR_RUN_OUT,
    output logic HEAD_LOAD_OUT,
    output logic SEEK_GO_OUT,
    output logic [9:0] SEEK_CYL_OUT,
    output logic FAN_CLEAR_OUT,
    // Diagnostics
    output logic FAULT_LEDS_OUT,
    output logic [7:0] STATUS_CODE_OUT
);

    dfs_state_type st_q, st_d;              // Controller state
    logic [7:0] code_q, code_d;             // Held status code
    logic [TMR_W-1:0] seek_cnt_q, seek_cnt_d; // Seek elapsed cycles
    logic [TMR_W-1:0] fan_cnt_q, fan_cnt_d; // Fan fault age
    logic [9:0] cyl_q, cyl_d;               // Seek target
    logic go_q, go_d;                       // Seek start pulse
    logic load_q, load_d;                   // Head load pulse
    logic armed_q, armed_d;                 // Clear seen after volt fault
    logic fan_clr_q, fan_clr_d;             // Fan clear attempt
    dfs_lines_type lines_q, lines_d;        // Registered lines
    logic fan_trip;                         // Fan fault held too long
    logic powered;                          // Past self test

    // Line levels for a state; seek end on cylinder and for seek-type errors
    function automatic dfs_lines_type lines_of(dfs_state_type s,
                                               logic [7:0] c);
        dfs_lines_type l;
        l = LINES_RST;
        l.on_cyl = (s == ST_READY);
        l.ready = (s == ST_READY) || (s == ST_SEEK) || (s == ST_RTZ);
        l.servo_en = l.ready || (s == ST_LOAD);
        l.seek_error = (s == ST_SEEK_ERR) || (s == ST_LOAD_FLT) ||
                       (s == ST_VFAULT);
        l.seek_end = (s == ST_READY) || (s == ST_LOAD_FLT) ||
                     ((s == ST_SEEK_ERR) && (c != CODE_LOST_CYL));
        l.fault = (s == ST_VFAULT) || (s == ST_LOAD_FLT) ||
                  (s == ST_HALT);
        // Motor idles in self test and after a fan stop
        l.motor_run = (s != ST_POST) && (s != ST_HALT) &&
                      (s != ST_FAN_STOP);
        l.leds_all = (s == ST_HALT);
        return l;
    endfunction

    // Saturating increment of a timer
    function automatic logic [TMR_W-1:0] tick(logic [TMR_W-1:0] v);
        return (&v) ? v : v + {{(TMR_W-1){1'b0}}, 1'b1};
    endfunction

    assign powered = (st_q != ST_POST) && (st_q != ST_HALT);
    // At least the hold time before the stop
    assign fan_trip = FAN_FAULT_IN && (fan_cnt_q >= TMR_W'(FAN_CYC)); // R8

    // Next state, code and command pulses
    always_comb begin
        st_d = st_q;
        code_d = code_q;
        seek_cnt_d = tick(seek_cnt_q);
        fan_cnt_d = FAN_FAULT_IN ? tick(fan_cnt_q) : '0;
        cyl_d = cyl_q;
        go_d = 1'b0;
        load_d = 1'b0;
        armed_d = armed_q;
        fan_clr_d = 1'b0;
        case (st_q)
            ST_POST: begin
                if (POST_DONE_IN) begin
                    if (MPU_FAIL_IN) begin
                        st_d = ST_HALT; // R11
                        code_d = CODE_MPU; // R11
                    end else if (PIA_FAIL_IN) begin
                        st_d = ST_HALT; // R10
                        code_d = CODE_PIA; // R10
                    end else begin
                        st_d = ST_LOAD;
                        load_d = 1'b1;
                    end
                end
            end
            ST_HALT: begin
                // No exit; only a reset restarts the self test
                st_d = ST_HALT; // R12
            end
            ST_LOAD: begin
                // Stale sense from before the load is ignored for two
                // cycles, as in a seek, so a reload cannot end at once
                if (SERVO_ERR_IN) begin
                    st_d = ST_LOAD_FLT;
                    code_d = CODE_SERVO;
                end else if (ON_CYL_SENSE_IN &&
                             (seek_cnt_q > TMR_W'(1))) begin
                    st_d = ST_READY;
                end
            end
            ST_LOAD_FLT: begin
                // Fault clear gives a fresh head load
                if (FAULT_CLEAR_IN) begin
                    st_d = ST_LOAD; // R4
                    load_d = 1'b1; // R4
                    code_d = CODE_NONE; // R14
                end
            end
            ST_READY: begin
                // Voltage fault outranks all but a fan trip while on cylinder
                if (VOLT_FAULT_IN) begin
                    st_d = ST_VFAULT; // R6
                    code_d = CODE_VOLT; // R6
                    armed_d = 1'b0;
                end else if (!ON_CYL_SENSE_IN) begin
                    st_d = ST_SEEK_ERR; // R1
                    code_d = CODE_LOST_CYL; // R1
                end else if (RTZ_IN) begin
                    st_d = ST_RTZ;
                    go_d = 1'b1;
                    cyl_d = CYL_HOME;
                    seek_cnt_d = '0;
                end else if (SEEK_REQ_IN) begin
                    if (CYL_ADDR_IN > CYL_MAX) begin
                        st_d = ST_SEEK_ERR; // R5
                        code_d = CODE_BAD_CYL; // R5
                    end else begin
                        st_d = ST_SEEK;
                        go_d = 1'b1;
                        cyl_d = CYL_ADDR_IN;
                        seek_cnt_d = '0;
                    end
                end
            end
            ST_SEEK, ST_RTZ: begin
                // Sense is ignored for two cycles while it drops
                if (SERVO_ERR_IN) begin
                    st_d = ST_SEEK_ERR; // R3
                    code_d = CODE_SERVO;
                end else if (ON_CYL_SENSE_IN &&
                             (seek_cnt_q > TMR_W'(1))) begin
                    st_d = ST_READY;
                end else if ((st_q == ST_SEEK) &&
                             (seek_cnt_q >= TMR_W'(SEEK_CYC - 1))) begin
                    st_d = ST_SEEK_ERR; // R13
                    code_d = CODE_SEEK_TMO; // R13
                end
            end
            ST_SEEK_ERR: begin
                // Each return command is a new attempt at zero
                if (RTZ_IN) begin
                    st_d = ST_RTZ; // R2 R3
                    go_d = 1'b1; // R2
                    cyl_d = CYL_HOME; // R2
                    seek_cnt_d = '0;
                    code_d = CODE_NONE; // R14
                end
            end
            ST_VFAULT: begin
                // Clear only counts once the voltage is good again
                if (!VOLT_FAULT_IN && FAULT_CLEAR_IN) begin
                    armed_d = 1'b1; // R7
                end
                if (armed_q && !VOLT_FAULT_IN && RTZ_IN) begin
                    st_d = ST_LOAD; // R7
                    load_d = 1'b1; // R7
                    code_d = CODE_NONE; // R14
                end
            end
            ST_FAN_STOP: begin
                fan_clr_d = 1'b1; // R9
                if (!FAN_FAULT_IN && !VOLT_FAULT_IN) begin
                    st_d = ST_LOAD; // R9
                    load_d = 1'b1; // R9
                    code_d = CODE_NONE; // R9
                end
            end
            default: begin
                st_d = ST_POST;
            end
        endcase
        // Fan handling overrides once the drive is up
        if (powered && fan_trip && (st_q != ST_FAN_STOP)) begin
            st_d = ST_FAN_STOP; // R8
            code_d = CODE_FAN; // R8
            go_d = 1'b0;
            load_d = 1'b0;
        end else if (powered && FAN_FAULT_IN && (st_q != ST_FAN_STOP)) begin
            fan_clr_d = 1'b1; // R9
            if (code_d == CODE_NONE) begin
                code_d = CODE_FAN; // R8
            end
        end
        // Every head load restarts the settle count
        if (load_d) begin
            seek_cnt_d = '0;
        end
        lines_d = lines_of(st_d, code_d);
    end

    // Registers; everything freezes while the enable is low
    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            st_q <= ST_POST; // R12
            code_q <= CODE_NONE;
            seek_cnt_q <= '0;
            fan_cnt_q <= '0;
            cyl_q <= CYL_HOME;
            go_q <= 1'b0;
            load_q <= 1'b0;
            armed_q <= 1'b0;
            fan_clr_q <= 1'b0;
            lines_q <= LINES_RST;
        end else if (CE_IN) begin
            st_q <= st_d;
            code_q <= code_d; // R14
            seek_cnt_q <= seek_cnt_d;
            fan_cnt_q <= fan_cnt_d;
            cyl_q <= cyl_d;
            go_q <= go_d;
            load_q <= load_d;
            armed_q <= armed_d;
            fan_clr_q <= fan_clr_d;
            lines_q <= lines_d;
        end
    end

    // Output wiring, all from flip-flops
    assign SEEK_ERROR_OUT = lines_q.seek_error;
    assign SEEK_END_OUT = lines_q.seek_end;
    assign ON_CYL_OUT = lines_q.on_cyl;
    assign READY_OUT = lines_q.ready;
    assign FAULT_OUT = lines_q.fault;
    assign SERVO_EN_OUT = lines_q.servo_en;
    assign MOTOR_RUN_OUT = lines_q.motor_run;
    assign FAULT_LEDS_OUT = lines_q.leds_all;
    assign HEAD_LOAD_OUT = load_q;
    assign SEEK_GO_OUT = go_q;
    assign SEEK_CYL_OUT = cyl_q;
    assign FAN_CLEAR_OUT = fan_clr_q;
    assign STATUS_CODE_OUT = code_q;

    // Checks
    property p_lost_cyl;
        @(posedge MCLK_IN) disable iff (!RST_N_IN)
        CE_IN && st_q == ST_READY && !VOLT_FAULT_IN && !ON_CYL_SENSE_IN &&
        !fan_trip |=> STATUS_CODE_OUT == CODE_LOST_CYL && SEEK_ERROR_OUT &&
        !ON_CYL_OUT && !SERVO_EN_OUT && MOTOR_RUN_OUT && !SEEK_END_OUT;
    endproperty
    a_lost_cyl: assert property (p_lost_cyl) // R1
        else $error("lost sense not reported");

    property p_rtz_clear;
        @(posedge MCLK_IN) disable iff (!RST_N_IN)
        CE_IN && st_q == ST_SEEK_ERR && RTZ_IN && !fan_trip |=>
        !SEEK_ERROR_OUT && SEEK_GO_OUT && SEEK_CYL_OUT == CYL_HOME;
    endproperty
    a_rtz_clear: assert property (p_rtz_clear) // R2
        else $error("return command did not restart seek");

    property p_rtz_servo;
        @(posedge MCLK_IN) disable iff (!RST_N_IN)
        CE_IN && st_q == ST_RTZ && SERVO_ERR_IN && !fan_trip |=>
        SEEK_ERROR_OUT && st_q == ST_SEEK_ERR && !SERVO_EN_OUT;
    endproperty
    a_rtz_servo: assert property (p_rtz_servo) // R3
        else $error("servo error in return not flagged");

    property p_load_retry;
        @(posedge MCLK_IN) disable iff (!RST_N_IN)
        CE_IN && st_q == ST_LOAD_FLT && FAULT_CLEAR_IN && !fan_trip |=>
        HEAD_LOAD_OUT && !FAULT_OUT ##1 !HEAD_LOAD_OUT || !CE_IN;
    endproperty
    a_load_retry: assert property (p_load_retry) // R4
        else $error("fault clear did not reload heads");

    property p_bad_cyl;
        @(posedge MCLK_IN) disable iff (!RST_N_IN)
        CE_IN && st_q == ST_READY && ON_CYL_SENSE_IN && !VOLT_FAULT_IN &&
        !RTZ_IN && SEEK_REQ_IN && CYL_ADDR_IN > CYL_MAX && !fan_trip |=>
        STATUS_CODE_OUT == CODE_BAD_CYL && SEEK_ERROR_OUT && SEEK_END_OUT &&
        !ON_CYL_OUT && !SERVO_EN_OUT && !SEEK_GO_OUT;
    endproperty
    a_bad_cyl: assert property (p_bad_cyl) // R5
        else $error("illegal cylinder not rejected");

    property p_volt;
        @(posedge MCLK_IN) disable iff (!RST_N_IN)
        CE_IN && st_q == ST_READY && VOLT_FAULT_IN && !fan_trip |=>
        STATUS_CODE_OUT == CODE_VOLT && !READY_OUT && SEEK_ERROR_OUT &&
        FAULT_OUT && !SERVO_EN_OUT && MOTOR_RUN_OUT;
    endproperty
    a_volt: assert property (p_volt) // R6
        else $error("voltage fault not reported");

    property p_volt_gate;
        @(posedge MCLK_IN) disable iff (!RST_N_IN)
        st_q == ST_VFAULT && !armed_q |=> st_q != ST_LOAD;
    endproperty
    a_volt_gate: assert property (p_volt_gate) // R7
        else $error("reload without prior fault clear");

    property p_fan_stop;
        @(posedge MCLK_IN) disable iff (!RST_N_IN)
        CE_IN && powered && FAN_FAULT_IN &&
        fan_cnt_q == TMR_W'(FAN_CYC) |=>
        !MOTOR_RUN_OUT && STATUS_CODE_OUT == CODE_FAN && !READY_OUT;
    endproperty
    a_fan_stop: assert property (p_fan_stop) // R8
        else $error("fan fault did not stop drive");

    property p_fan_restart;
        @(posedge MCLK_IN) disable iff (!RST_N_IN)
        CE_IN && st_q == ST_FAN_STOP && !FAN_FAULT_IN && !VOLT_FAULT_IN |=>
        HEAD_LOAD_OUT && MOTOR_RUN_OUT && STATUS_CODE_OUT == CODE_NONE;
    endproperty
    a_fan_restart: assert property (p_fan_restart) // R9
        else $error("drive not restarted after fan clear");

    property p_halt;
        @(posedge MCLK_IN) disable iff (!RST_N_IN)
        CE_IN && st_q == ST_POST && POST_DONE_IN && PIA_FAIL_IN &&
        !MPU_FAIL_IN |=> STATUS_CODE_OUT == CODE_PIA && FAULT_LEDS_OUT
        ##1 FAULT_LEDS_OUT && STATUS_CODE_OUT == CODE_PIA;
    endproperty
    a_halt: assert property (p_halt) // R10
        else $error("adapter test failure not held");

    property p_halt_hold;
        @(posedge MCLK_IN) disable iff (!RST_N_IN)
        st_q == ST_HALT |=> st_q == ST_HALT && $stable(STATUS_CODE_OUT);
    endproperty
    a_halt_hold: assert property (p_halt_hold) // R11 R12
        else $error("self-test halt left without reset");

    property p_seek_tmo;
        @(posedge MCLK_IN) disable iff (!RST_N_IN)
        st_q == ST_SEEK |-> seek_cnt_q < TMR_W'(SEEK_CYC);
    endproperty
    a_seek_tmo: assert property (p_seek_tmo) // R13
        else $error("seek ran past its timeout");

    property p_code_hold;
        @(posedge MCLK_IN) disable iff (!RST_N_IN)
        CE_IN && st_q == ST_SEEK_ERR && !RTZ_IN && !FAN_FAULT_IN |=>
        $stable(STATUS_CODE_OUT);
    endproperty
    a_code_hold: assert property (p_code_hold) // R14
        else $error("status code changed without recovery");

endmodule

// [test/dfs_drive_side_model.sv]
/*
 * Far-side drive model: answers head loads and seeks with on-cylinder
 * sense after a settle delay, promptly or slowly as the bench asks.
 * Assumes the block's single 10 MHz clock and synchronous reset.
 */
`timescale 1ns/1ps
module dfs_drive_side_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Motion start and behaviour knobs
    input wire logic go,
    input wire logic [7:0] settle,
    input wire logic lose,
    // Sense back to the block
    output logic sense
);
    logic sense_q; // Heads settled on cylinder
    logic [7:0] cnt_q; // Cycles left before settling

    // Any motion start drops sense at once; a long settle models a
    // stuck actuator, so the bench can provoke the seek timeout
    always @(posedge clk) begin
        if (!rst_n) begin
            sense_q <= 1'b0;
            cnt_q <= 8'h00;
        end else if (go) begin
            sense_q <= 1'b0;
            cnt_q <= settle;
        end else if (cnt_q > 8'h01) begin
            cnt_q <= cnt_q - 8'h01;
        end else if (cnt_q == 8'h01) begin
            cnt_q <= 8'h00;
            sense_q <= 1'b1;
        end
    end

    // Forced loss overrides the settled level
    assign sense = sense_q & ~lose;
endmodule

// [test/dfs_drive_fault_tb.sv]
/*
 * Self-checking bench for the drive fault and status-code block.
 * Assumes the block's timing figures are shortened to 20 and 30 cycles;
 * a model on the far side answers seeks with on-cylinder sense.
 */
`timescale 1ns/1ps
module dfs_drive_fault_tb
    import dfs_pkg::*;
;
    // Stimulus
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic post_done = 1'b0, pia_fail = 1'b0, mpu_fail = 1'b0;
    logic seek_req = 1'b0, return_to_track_zero = 1'b0, fclr = 1'b0;
    logic servo_err = 1'b0, volt = 1'b0, fan = 1'b0, lose = 1'b0;
    logic [9:0] cyl = 10'h000;
    logic [7:0] settle = 8'h05;
    logic ce = 1'b1;
    // Observed
    logic sense, se, send, oc, rdy, flt, servo_en, motor;
    logic hload, sgo, fan_clr, leds;
    logic [9:0] scyl;
    logic [7:0] code;
    // Bookkeeping: notes hold {code, error, end, on cyl, ready, fault}
    int fail_count = 0;
    int num_checks = 0;
    logic [12:0] note_q[$];
    logic [7:0] last_code = 8'hxx;

    always #50 mclk = ~mclk;

    dfs_drive_fault #(.SEEK_CYC(20), .FAN_CYC(30)) dfs_drive_fault_inst (
        .MCLK_IN(mclk), .RST_N_IN(rst_n), .CE_IN(ce),
        .POST_DONE_IN(post_done), .PIA_FAIL_IN(pia_fail),
        .MPU_FAIL_IN(mpu_fail), .SEEK_REQ_IN(seek_req),
        .CYL_ADDR_IN(cyl), .RTZ_IN(return_to_track_zero), .FAULT_CLEAR_IN(fclr),
        .ON_CYL_SENSE_IN(sense), .SERVO_ERR_IN(servo_err),
        .VOLT_FAULT_IN(volt), .FAN_FAULT_IN(fan),
        .SEEK_ERROR_OUT(se), .SEEK_END_OUT(send), .ON_CYL_OUT(oc),
        .READY_OUT(rdy), .FAULT_OUT(flt), .SERVO_EN_OUT(servo_en),
        .MOTOR_RUN_OUT(motor), .HEAD_LOAD_OUT(hload),
        .SEEK_GO_OUT(sgo), .SEEK_CYL_OUT(scyl),
        .FAN_CLEAR_OUT(fan_clr), .FAULT_LEDS_OUT(leds),
        .STATUS_CODE_OUT(code));

    dfs_drive_side_model dfs_drive_side_model_inst (
        .clk(mclk), .rst_n(rst_n), .go(sgo | hload),
        .settle(settle), .lose(lose), .sense(sense));

    // Compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Single exit point for the run
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Every code change must match the oldest note
    always @(posedge mclk) begin
        #1;
        if (code !== last_code) begin
            last_code = code;
            if (note_q.size() == 0) begin
                fail_count++;
                $display("BAD %0t unexpected code %h", $time, code);
            end else begin
                check({3'h0, code, se, send, oc, rdy, flt},
                      {3'h0, note_q.pop_front()});
            end
        end
    end

    // Wait targets: 0 settled, 1 motor stopped, 2 notes drained
    function automatic bit reached(input logic [1:0] sel);
        case (sel)
            2'h0: return rdy === 1'b1 && oc === 1'b1;
            2'h1: return motor === 1'b0;
            default: return note_q.size() == 0;
        endcase
    endfunction

    // Bounded wait; a hang ends the run
    task automatic wait_for(input logic [1:0] sel);
        int n;
        n = 0;
        while (!reached(sel) && n < 300) begin
            @(negedge mclk);
            n++;
        end
        if (n == 300) begin
            fail_count++;
            $display("BAD %0t wait %0d expired", $time, sel);
            close_out();
        end
    endtask

    // One-cycle command: 0 return, 1 clear, 2 servo error, 3 seek
    task automatic pulse(input logic [1:0] sel);
        @(negedge mclk);
        case (sel)
            2'h0: return_to_track_zero = 1'b1;
            2'h1: fclr = 1'b1;
            2'h2: servo_err = 1'b1;
            default: seek_req = 1'b1;
        endcase
        @(negedge mclk);
        return_to_track_zero = 1'b0;
        fclr = 1'b0;
        servo_err = 1'b0;
        seek_req = 1'b0;
    endtask

    // Breaker cycle; the held code falls back to none
    task automatic do_reset;
        if (code !== 8'h00) note_q.push_back(13'h0000);
        post_done = 1'b0;
        rst_n = 1'b0;
        repeat (4) @(negedge mclk);
        rst_n = 1'b1;
    endtask

    // Return to track zero from a seek error, ends on cylinder zero
    task automatic recover;
        note_q.push_back({8'h00, 5'b00010});
        pulse(2'h0);
        wait_for(2'h2);
        wait_for(2'h0);
        check({6'h00, scyl}, 16'h0000);
    endtask

    initial begin
        logic [9:0] a;
        void'($urandom(18704));
        do_reset();
        post_done = 1'b1;
        wait_for(2'h0);
        // Legal seeks, the top cylinder first
        for (int i = 0; i < 4; i++) begin
            settle = 8'($urandom_range(8, 3));
            a = (i == 0) ? CYL_MAX : 10'($urandom_range(822, 0));
            cyl = a;
            pulse(2'h3);
            wait_for(2'h0);
            check({6'h00, scyl}, {6'h00, a});
            check({8'h00, code}, 16'h0000);
        end
        // One past the top is refused
        note_q.push_back({8'h4d, 5'b11000});
        cyl = CYL_MAX + 10'h001;
        pulse(2'h3);
        wait_for(2'h2);
        check({14'h0, servo_en, motor}, 16'h0001);
        recover();
        // Stuck actuator trips the seek timeout
        settle = 8'h28;
        note_q.push_back({8'h46, 5'b11000});
        cyl = 10'($urandom_range(822, 0));
        pulse(2'h3);
        wait_for(2'h2);
        check({15'h0, servo_en}, 16'h0000);
        settle = 8'h05;
        recover();
        // Lost sense while idle
        note_q.push_back({8'h4b, 5'b10000});
        lose = 1'b1;
        wait_for(2'h2);
        check({14'h0, servo_en, motor}, 16'h0001);
        lose = 1'b0;
        recover();
        // Servo error during the return, then a second return
        note_q.push_back({8'h4b, 5'b10000});
        lose = 1'b1;
        wait_for(2'h2);
        lose = 1'b0;
        settle = 8'h14;
        note_q.push_back({8'h00, 5'b00010});
        pulse(2'h0);
        wait_for(2'h2);
        note_q.push_back({8'h4a, 5'b11000});
        pulse(2'h2);
        wait_for(2'h2);
        settle = 8'h05;
        recover();
        // Voltage fault on cylinder; clear refused while it lasts
        note_q.push_back({8'h4e, 5'b10001});
        volt = 1'b1;
        wait_for(2'h2);
        check({14'h0, servo_en, motor}, 16'h0001);
        pulse(2'h1);
        repeat (2) @(negedge mclk);
        check({8'h00, code}, 16'h004e);
        volt = 1'b0;
        pulse(2'h1);
        settle = 8'h14;
        note_q.push_back({8'h00, 5'b00000});
        pulse(2'h0);
        wait_for(2'h2);
        // Servo error in the reload, fault clear loads again
        note_q.push_back({8'h4a, 5'b11001});
        pulse(2'h2);
        wait_for(2'h2);
        settle = 8'h05;
        note_q.push_back({8'h00, 5'b00000});
        pulse(2'h1);
        wait_for(2'h0);
        // Fan fault: code at once, stop only after the hold time
        note_q.push_back({8'h5c, 5'b01110});
        fan = 1'b1;
        repeat (25) @(negedge mclk);
        check({14'h0, fan_clr, motor}, 16'h0003);
        wait_for(2'h1);
        check({11'h0, se, send, oc, rdy, flt}, 16'h0000);
        note_q.push_back({8'h00, 5'b00000});
        fan = 1'b0;
        wait_for(2'h0);
        // Enable low freezes everything, even a lost sense
        ce = 1'b0;
        lose = 1'b1;
        repeat (3) @(negedge mclk);
        check({7'h00, rdy, code}, 16'h0100);
        lose = 1'b0;
        ce = 1'b1;
        // Self-test failures halt until a breaker cycle
        do_reset();
        note_q.push_back({8'h5f, 5'b00001});
        pia_fail = 1'b1;
        post_done = 1'b1;
        wait_for(2'h2);
        check({14'h0, leds, motor}, 16'h0002);
        pulse(2'h1);
        pulse(2'h0);
        check({8'h00, code}, 16'h005f);
        do_reset();
        note_q.push_back({8'hff, 5'b00001});
        mpu_fail = 1'b1;
        post_done = 1'b1;
        wait_for(2'h2);
        check({15'h0, leds}, 16'h0001);
        do_reset();
        mpu_fail = 1'b0;
        pia_fail = 1'b0;
        post_done = 1'b1;
        wait_for(2'h0);
        check({7'h00, leds, code}, 16'h0000);
        close_out();
    end
endmodule
